// file: include/fbp_pkg.sv
// constants and types for the flash block protect unit
// ==========================================================
package fbp_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned REG_W = 8;
    localparam int unsigned APB_AW = 18;
    localparam int unsigned WORD_LSB = 2;
    localparam int unsigned STRB_LANE = 0;
    // the register location counts words; the bus byte address is four times it
    localparam logic [APB_AW-WORD_LSB-1:0] FLASH_PROTECT_START_IDX = 16'hfe09;
    localparam logic [APB_AW-1:0] FLASH_PROTECT_START_BYTE = 18'h3_f824;
    localparam logic [REG_W-1:0] PROTECT_START_RESET = 8'h00;
    localparam logic [REG_W-1:0] PROTECT_START_ALL = 8'h00;
    localparam logic [REG_W-1:0] PROTECT_START_OPEN = 8'hff;
    localparam logic [ADDR_W-1:0] TOP_ADDR = 16'hffff;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ONE_ADDR = 16'h0001;
    localparam int unsigned CMP_HI = 15;
    localparam int unsigned CMP_LO = 9;
    localparam int unsigned REG_HI = 7;
    localparam int unsigned REG_LO = 1;
    localparam int unsigned LOW_ZERO_W = 9;
    localparam logic [LOW_ZERO_W-1:0] LOW_ZERO = 9'h000;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : fbp_pkg

// file: include/fbp_cmp_if.sv
// carrier between the register unit and the compare unit
`timescale 1ns/1ps
interface fbp_cmp_if;
    logic [7:0] protect_start_bits;
    logic [15:0] target_addr;
    logic hit;
    modport ctl (output protect_start_bits, output target_addr, input hit);
    modport cmp (input protect_start_bits, input target_addr, output hit);
endinterface : fbp_cmp_if

// file: verilog/fbp_cmp.sv
// address compare for the protected region
`timescale 1ns/1ps
module fbp_cmp (
    fbp_cmp_if.cmp c
);
    logic [15:0] start_addr;
    always_comb begin
        start_addr = {c.protect_start_bits[fbp_pkg::REG_HI:fbp_pkg::REG_LO], fbp_pkg::LOW_ZERO};
        if (c.protect_start_bits == fbp_pkg::PROTECT_START_OPEN) begin
            c.hit = 1'b0;
        end else begin
            // start to top inclusive; all zeros gives start 0 and covers everything
            c.hit = c.target_addr[fbp_pkg::CMP_HI:fbp_pkg::CMP_LO] >= start_addr[fbp_pkg::CMP_HI:fbp_pkg::CMP_LO];
        end
    end
endmodule : fbp_cmp

// file: verilog/fbp_top.sv
// flash block protect unit: apb register and high voltage gate
`timescale 1ns/1ps
module fbp_top #(
    parameter int unsigned ADDR_W = 16,
    parameter int unsigned REG_W = 8,
    parameter int unsigned DATA_W = 32,
    parameter int unsigned APB_AW = 18
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W/8-1:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ADDR_W-1:0] target_addr,
    input wire logic high_voltage_enable_req,
    output logic high_voltage_enable,
    output logic protect_hit,
    output logic [REG_W-1:0] flash_protect_start
);
    // ==========================================================
    // local signals
    fbp_cmp_if cif ();
    wire logic [REG_W-1:0] start_r;
    logic setup_w;
    logic access_w;
    logic sel_reg;
    logic wr_take;
    logic rd_sel;
    logic hit_w;
    logic open_w;
    logic [ADDR_W-1:0] start_addr_w;
    logic [ADDR_W-1:0] below_addr_w;
    typedef enum {bus_idle, bus_answer} fbp_bus_state_t;
    fbp_bus_state_t state_r;
    fbp_bus_state_t state_nxt;

    // ==========================================================
    // bus decode
    assign setup_w = psel && !penable;
    // the write lands only on the edge where the master sees pready, never on the setup edge
    assign access_w = psel && penable && pready;
    assign sel_reg = (paddr[APB_AW-1:fbp_pkg::WORD_LSB] == fbp_pkg::FLASH_PROTECT_START_IDX);
    // a write with the low byte lane off is ignored but still answered
    assign wr_take = clk_en && access_w && pwrite && sel_reg && pstrb[fbp_pkg::STRB_LANE];
    assign rd_sel = !pwrite && sel_reg;

    // ==========================================================
    // bus state
    // no wait state: a setup cycle always leads to exactly one answer cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bus_idle: begin
                if (setup_w) begin
                    state_nxt = bus_answer;
                end
            end
            bus_answer: begin
                // the access edge ends the transfer; a new setup only follows it
                state_nxt = setup_w ? bus_answer : bus_idle;
            end
            default: begin
                state_nxt = bus_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= bus_idle;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // bus answer
    // pready stands for the access cycle only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (clk_en) begin
            pready <= (state_nxt == bus_answer);
        end
    end

    // an unmapped word is refused with an error and leaves every register alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pslverr <= setup_w && !sel_reg;
        end
    end

    // read data is captured at setup so it stands through the whole access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= fbp_pkg::RDATA_ZERO;
        end else if (clk_en && setup_w) begin
            prdata <= rd_sel ? DATA_W'(start_r) : fbp_pkg::RDATA_ZERO;
        end
    end

    // ==========================================================
    // protect register
    // reset value protects the whole array until software opens part of it
    for (genvar gi = 0; gi < REG_W; gi++) begin : g_bit
        logic bit_r;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                bit_r <= fbp_pkg::PROTECT_START_RESET[gi];
            end else if (wr_take) begin
                bit_r <= pwdata[gi];
            end
        end
        assign start_r[gi] = bit_r;
    end

    // ==========================================================
    // protection compare
    assign cif.protect_start_bits = start_r;
    assign cif.target_addr = target_addr;
    assign hit_w = cif.hit;
    fbp_cmp u_cmp (
        .c(cif.cmp)
    );

    // helpers for the checks below, not used by the gate
    assign open_w = (start_r == fbp_pkg::PROTECT_START_OPEN);
    assign start_addr_w = {start_r[fbp_pkg::REG_HI:fbp_pkg::REG_LO], fbp_pkg::LOW_ZERO};
    assign below_addr_w = start_addr_w - fbp_pkg::ONE_ADDR;

    // ==========================================================
    // high voltage gate
    // the gate costs one cycle of latency so the output is a clean flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_voltage_enable <= 1'b0;
        end else if (clk_en) begin
            high_voltage_enable <= high_voltage_enable_req && !hit_w;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect_hit <= 1'b0;
        end else if (clk_en) begin
            protect_hit <= hit_w;
        end
    end

    // visible copy of the register for the program/erase controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_protect_start <= fbp_pkg::PROTECT_START_RESET;
        end else if (clk_en) begin
            flash_protect_start <= start_r;
        end
    end

    // ==========================================================
    // checks
    // the region checks use the live register start_r and the live target address; the copy, write and AST_HV_BLOCKED checks compare against $past values

    // a protected target never leaves the gate high
    AST_HV_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(clk_en) && $past(hit_w)) |-> !high_voltage_enable)
        else $error("hv set in protected region");

    // an open target passes the request through
    AST_HV_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !hit_w && high_voltage_enable_req) |=> high_voltage_enable)
        else $error("hv request lost in open region");

    // no request, no high voltage
    AST_HV_NO_REQ: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !high_voltage_enable_req) |=> !high_voltage_enable)
        else $error("hv set without request");

    // the top address is never opened while any region exists
    AST_TOP_HV: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !open_w && target_addr == fbp_pkg::TOP_ADDR) |=> !high_voltage_enable)
        else $error("hv set at top address");

    // the word just below the start stays programmable
    AST_BELOW_HV: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && high_voltage_enable_req && !open_w && start_addr_w != fbp_pkg::ADDR_ZERO
            && target_addr == below_addr_w) |=> high_voltage_enable)
        else $error("hv blocked below start");

    // all zeros protects everything
    AST_ZERO_ALL: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && start_r == fbp_pkg::PROTECT_START_ALL) |=> protect_hit)
        else $error("zero register did not protect");

    // all zeros: the compare itself must flag every address
    AST_ZERO_HIT: assert property (@(posedge pclk) disable iff (!presetn)
        (start_r == fbp_pkg::PROTECT_START_ALL) |-> hit_w)
        else $error("zero register compare open");

    // all ones opens everything
    AST_ONES_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && open_w && high_voltage_enable_req) |=> high_voltage_enable)
        else $error("all ones register blocked hv");

    // all ones: the compare never flags
    AST_ONES_NO_HIT: assert property (@(posedge pclk) disable iff (!presetn)
        open_w |-> !hit_w)
        else $error("all ones register flagged hit");

    // the region always reaches the top address
    AST_TOP_HIT: assert property (@(posedge pclk) disable iff (!presetn)
        (!open_w && target_addr == fbp_pkg::TOP_ADDR) |-> hit_w)
        else $error("top address not protected");

    // the start address itself is inside the region
    AST_START_HIT: assert property (@(posedge pclk) disable iff (!presetn)
        (!open_w && target_addr == start_addr_w) |-> hit_w)
        else $error("start address not protected");

    // the hit output follows the compare by one cycle
    AST_HIT_COPY: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> (protect_hit == $past(hit_w)))
        else $error("hit output wrong");

    // register bits map onto the upper address bits
    AST_START_MAP: assert property (@(posedge pclk) disable iff (!presetn)
        (!open_w) |-> (hit_w == (target_addr[fbp_pkg::CMP_HI:fbp_pkg::CMP_LO]
            >= start_r[fbp_pkg::REG_HI:fbp_pkg::REG_LO])))
        else $error("start compare wrong");

    // below the start is open
    AST_BELOW_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
        (!open_w && start_addr_w != fbp_pkg::ADDR_ZERO && target_addr == below_addr_w) |-> !hit_w)
        else $error("address below start protected");

    // a taken write lands at the access edge
    AST_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_take |=> (start_r == $past(pwdata[REG_W-1:0])))
        else $error("register write lost");

    // nothing else moves the register
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_take) |=> $stable(start_r))
        else $error("register changed without write");

    // the setup edge alone never writes
    AST_SETUP_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup_w) |=> $stable(start_r))
        else $error("write on setup edge");

    // a refused access leaves the register alone
    AST_NO_WRITE_ON_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && access_w && !sel_reg) |=> $stable(start_r))
        else $error("unmapped write changed register");

    // low lane off: the write is ignored
    AST_STROBE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && access_w && pwrite && sel_reg && !pstrb[fbp_pkg::STRB_LANE]) |=> $stable(start_r))
        else $error("strobe ignored");

    // a read answers with the register in the next cycle
    AST_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup_w && rd_sel) |=> (pready && prdata == DATA_W'(start_r)))
        else $error("register read wrong");

    // writes and unmapped reads return zero
    AST_WRITE_RDATA: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup_w && !rd_sel) |=> (prdata == fbp_pkg::RDATA_ZERO))
        else $error("read data not zero");

    // the upper data bits are always zero
    AST_RDATA_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> ((prdata >> REG_W) == fbp_pkg::RDATA_ZERO))
        else $error("upper read data not zero");

    // pready stands for one cycle
    AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && clk_en) |=> !pready)
        else $error("pready longer than one cycle");

    // the error only comes with the answer
    AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");

    // an unmapped setup is answered with an error
    AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup_w && !sel_reg) |=> (pready && pslverr))
        else $error("unmapped access not refused");

    // a low enable freezes every state
    AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
        (!clk_en) |=> ($stable(start_r) && $stable(pready) && $stable(prdata) && $stable(high_voltage_enable)))
        else $error("state moved while frozen");

    // the visible copy follows the register by one cycle
    AST_COPY_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> (flash_protect_start == $past(start_r)))
        else $error("register copy wrong");
endmodule : fbp_top

// file: tb/fbp_seq_model.sv
// flash sequencer model presenting a target address and a high voltage request
`timescale 1ns/1ps
module fbp_seq_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [16:0] cmd,
    output logic [15:0] target_addr,
    output logic high_voltage_enable_req
);
    // registered, so the block sees the request only after an edge, as from real control logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) {high_voltage_enable_req, target_addr} <= 17'h0_0000;
        else {high_voltage_enable_req, target_addr} <= cmd;
    end
endmodule : fbp_seq_model

// file: tb/flash_block_protect_tb.sv
// self-checking bench for the flash block protect unit
`timescale 1ns/1ps
module flash_block_protect_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h0_0000;
    logic [15:0] t_addr;
    logic ce = 1'b1;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, hv, hit, t_req, se;
    logic [7:0] fps;
    logic [16:0] cmd = 17'h0_0000;
    logic [7:0] regv [5] = '{8'h00, 8'hfe, 8'hff, 8'h81, 8'h80};
    int err_total = 0, comparisons = 0, cyc = 0;
    initial forever #12.5 pclk = ~pclk;
    fbp_seq_model seq_u (.pclk(pclk), .presetn(presetn), .cmd(cmd), .target_addr(t_addr),
        .high_voltage_enable_req(t_req));
    fbp_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .target_addr(t_addr), .high_voltage_enable_req(t_req),
        .high_voltage_enable(hv), .protect_hit(hit), .flash_protect_start(fps));
    // ==========================================================
    // shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task probe(input logic [15:0] a, input logic [7:0] r);
        logic p;
        p = (r !== 8'hff) && (a[15:9] >= r[7:1]);
        cmd <= {1'b1, a};
        repeat (3) @(posedge pclk);
        check(32'(hv), 32'(!p));
        check(32'(hit), 32'(p));
    endtask : probe
    // ==========================================================
    // scenarios
    task t_reset();
        apb(1'b0, fbp_pkg::FLASH_PROTECT_START_BYTE, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        probe(16'h0000, 8'h00);
        probe(16'hffff, 8'h00);
        $display("done reset");
    endtask : t_reset
    task t_regions();
        logic [15:0] s;
        foreach (regv[i]) begin
            s = {regv[i][7:1], 9'h000};
            apb(1'b1, fbp_pkg::FLASH_PROTECT_START_BYTE, {24'h00_0000, regv[i]});
            apb(1'b0, fbp_pkg::FLASH_PROTECT_START_BYTE, 32'h0000_0000);
            check(rd, {24'h00_0000, regv[i]});
            check(32'(fps), 32'(regv[i]));
            probe(s, regv[i]);
            probe(s - 16'h0001, regv[i]);
            probe(16'hffff, regv[i]);
        end
        $display("done regions");
    endtask : t_regions
    task t_unmapped();
        apb(1'b1, 18'h0_1000, 32'h0000_0011);
        check(32'(se), 32'h0000_0001);
        check(32'(fps), 32'h0000_0080);
        $display("done unmapped");
    endtask : t_unmapped
    task t_freeze();
        ce <= 1'b0;
        cmd <= {1'b1, 16'h0000};
        repeat (3) @(posedge pclk);
        check(32'(hv), 32'h0000_0000);
        ce <= 1'b1;
        repeat (3) @(posedge pclk);
        check(32'(hv), 32'h0000_0001);
        $display("done freeze");
    endtask : t_freeze
    task wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    always @(posedge pclk) begin
        if (++cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_regions();
        t_unmapped();
        t_freeze();
        wrap_up();
    end
endmodule : flash_block_protect_tb
